// ===== hw/angle_pkg.sv
package angle_pkg;
    localparam int TW          = 24;
    localparam int NB          = 3;
    localparam int RECIP_EXTRA = 16;
    localparam int RES_SHIFT   = 3;
    localparam int SYNC_STAGES = 3;
    localparam int DIR_HOLD    = 5;

    // byte offsets of the register words
    localparam logic [7:0] A_CTRL    = 8'h00;
    localparam logic [7:0] A_STATUS  = 8'h04;
    localparam logic [7:0] A_NOTIFY  = 8'h08;
    localparam logic [7:0] A_ENABLE  = 8'h0C;
    localparam logic [7:0] A_FORCE   = 8'h10;
    localparam logic [7:0] A_TLR     = 8'h14;
    localparam logic [7:0] A_PVT     = 8'h18;
    localparam logic [7:0] A_MPV     = 8'h1C;
    localparam logic [7:0] A_PSTC    = 8'h20;
    localparam logic [7:0] A_PSSC    = 8'h24;
    localparam logic [7:0] A_RCDT_T  = 8'h28;
    localparam logic [7:0] A_RCDT_S  = 8'h2C;
    localparam logic [7:0] A_NOM_T   = 8'h30;
    localparam logic [7:0] A_NOM_S   = 8'h34;
    localparam logic [7:0] A_ADDEND  = 8'h38;

    // notification bit positions
    localparam int N_TOR = 0;
    localparam int N_DCG = 1;
    localparam int N_PWI = 2;

    // status bit positions
    localparam int S_TOR  = 0;
    localparam int S_SYT  = 1;
    localparam int S_SYS  = 2;
    localparam int S_DIR  = 3;
    localparam int S_PCP  = 4;
    localparam int S_OVT  = 5;
    localparam int S_OVS  = 6;

    localparam int CTRL_W = 9;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

    typedef struct packed {
        logic sync_s;
        logic sync_t;
        logic pc_down;
        logic pc_req;
        logic emergency;
        logic fast_corr;
        logic dir_sel;
        logic synchronous_motor_control;
        logic res_mode;
    } ctrl_type;

    localparam ctrl_type CTRL_RESET = '0;

    typedef struct packed {
        logic trigger;
        logic state;
        logic dir_internal;
    } event_type;
endpackage : angle_pkg

// ===== hw/recip_unit.sv
`timescale 1ns/1ns
module recip_unit #(
    parameter int TW = angle_pkg::TW
) (
    input  wire logic [TW-1:0] duration,
    output logic      [TW-1:0] result,
    output logic               overflow
);
    localparam int SH = TW + angle_pkg::RECIP_EXTRA;
    localparam int QW = SH + 1;

    logic [QW-1:0] quotient;

    // a full divider is costly; it is shared by nothing and settles in one cycle
    assign quotient = duration == '0 ? '0 : (QW'(1) << SH) / QW'(duration);
    assign overflow = (duration == '0) || (quotient[QW-1:TW] != '0);
    assign result   = overflow ? '1 : quotient[TW-1:0]; // RL13
endmodule : recip_unit

// ===== hw/angle_clock_tracking_unit.sv
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
// Overview of operation
// RL1: out of range when stamp plus duration times tolerance exceeds time, no trigger
// RL2: out of range sets status flag and notification in every mode combination
// RL3: writing one to force bit raises the out-of-range notification
// RL4: motor control or direction select one takes direction from the pin
// RL5: each direction change clears plausibility value, suppressing the check
// RL6: active check flags violation when an increment is shorter than plausibility value
// RL7: plausibility value writable by CPU bus or sequencer port
// RL8: each direction change sets the direction-change notification
// RL9: a correction request changes missing-pulse value exactly once
// RL10: software avoids enabling fast correction during a pending correction
// RL11: unsynchronized trigger path keeps trigger position counter on direction change
// RL12: unsynchronized state path keeps state position counter on direction change
// RL13: reciprocal overflow saturates result to all ones
// RL14: overflow stored in trigger result normally, state result in emergency
// RL15: nominal reciprocals follow results; addend chosen by configured mode
// RL16: notifications stay set until cleared; enables gate them to interrupts
module angle_clock_tracking_unit #(
    parameter int TW = angle_pkg::TW
) (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    input  wire angle_pkg::event_type  events,
    input  wire logic [TW-1:0]         base_time_counter,
    input  wire logic                  trigger_direction_input,
    input  wire logic                  seq_pvt_we,
    input  wire logic [TW-1:0]         seq_pvt_wdata,
    input  wire logic                  seq_force_tor,
    output logic [angle_pkg::NB-1:0]   irq,
    output logic [TW-1:0]              pulse_generator_addend
);
    localparam int NB = angle_pkg::NB;
    localparam int LW = TW + 9;

    if (TW < 16 || TW > 31) begin : g_bad_width
        $error("TW must lie between 16 and 31");
    end

    angle_pkg::ctrl_type ctrl_q;
    angle_pkg::ctrl_type wctrl;
    logic [7:0]          tlr_q;
    logic [TW-1:0]       pvt_q;
    logic [15:0]         mpv_q;
    logic [TW-1:0]       pstc_q;
    logic [TW-1:0]       pssc_q;
    logic [TW-1:0]       rcdt_t_q;
    logic [TW-1:0]       rcdt_s_q;
    logic [TW-1:0]       nom_t_q;
    logic [TW-1:0]       nom_s_q;
    logic [NB-1:0]       notify_q;
    logic [NB-1:0]       enable_q;
    logic                tor_flag_q;
    logic                ovf_t_q;
    logic                ovf_s_q;
    logic [TW-1:0]       ts_q;
    logic [TW-1:0]       ts_s_q;
    logic [TW-1:0]       dt_q;
    logic                arm_q;
    logic                dir_t_q;
    logic                dir_s_q;
    logic                pc_pend_q;
    logic [angle_pkg::SYNC_STAGES-1:0] pin_s_q;
    logic                dir_pin_q;
    logic                wr_pend_q;
    logic [7:0]          wr_addr_q;
    logic [31:0]         rd_d;

    // bus side
    logic take;
    logic wr;
    assign take      = hsel & hready & (htrans == angle_pkg::HTRANS_NONSEQ);
    assign wr        = wr_pend_q;
    assign wctrl     = angle_pkg::ctrl_type'(hwdata[angle_pkg::CTRL_W-1:0]);
    assign hreadyout = 1'b1;
    assign hresp     = angle_pkg::HRESP_OKAY;

    logic w_ctrl, w_notify, w_enable, w_force, w_tlr, w_pvt, w_mpv, w_pstc, w_pssc, w_status;
    assign w_ctrl   = wr && wr_addr_q == angle_pkg::A_CTRL;
    assign w_status = wr && wr_addr_q == angle_pkg::A_STATUS;
    assign w_notify = wr && wr_addr_q == angle_pkg::A_NOTIFY;
    assign w_enable = wr && wr_addr_q == angle_pkg::A_ENABLE;
    assign w_force  = wr && wr_addr_q == angle_pkg::A_FORCE;
    assign w_tlr    = wr && wr_addr_q == angle_pkg::A_TLR;
    assign w_pvt    = wr && wr_addr_q == angle_pkg::A_PVT;
    assign w_mpv    = wr && wr_addr_q == angle_pkg::A_MPV;
    assign w_pstc   = wr && wr_addr_q == angle_pkg::A_PSTC;
    assign w_pssc   = wr && wr_addr_q == angle_pkg::A_PSSC;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= take & hwrite;
            if (take) begin
                wr_addr_q <= haddr[7:0];
            end
        end
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        case (haddr[7:0])
            angle_pkg::A_CTRL:   rd_d = 32'(ctrl_q);
            angle_pkg::A_STATUS: begin
                rd_d[angle_pkg::S_TOR] = tor_flag_q;
                rd_d[angle_pkg::S_SYT] = ctrl_q.sync_t;
                rd_d[angle_pkg::S_SYS] = ctrl_q.sync_s;
                rd_d[angle_pkg::S_DIR] = dir_t_q;
                rd_d[angle_pkg::S_PCP] = pc_pend_q;
                rd_d[angle_pkg::S_OVT] = ovf_t_q;
                rd_d[angle_pkg::S_OVS] = ovf_s_q;
            end
            angle_pkg::A_NOTIFY: rd_d = 32'(notify_q);
            angle_pkg::A_ENABLE: rd_d = 32'(enable_q);
            angle_pkg::A_TLR:    rd_d = 32'(tlr_q);
            angle_pkg::A_PVT:    rd_d = 32'(pvt_q);
            angle_pkg::A_MPV:    rd_d = 32'(mpv_q);
            angle_pkg::A_PSTC:   rd_d = 32'(pstc_q);
            angle_pkg::A_PSSC:   rd_d = 32'(pssc_q);
            angle_pkg::A_RCDT_T: rd_d = 32'(rcdt_t_q);
            angle_pkg::A_RCDT_S: rd_d = 32'(rcdt_s_q);
            angle_pkg::A_NOM_T:  rd_d = 32'(nom_t_q);
            angle_pkg::A_NOM_S:  rd_d = 32'(nom_s_q);
            angle_pkg::A_ADDEND: rd_d = 32'(pulse_generator_addend);
            default:             rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            hrdata <= rd_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q   <= angle_pkg::CTRL_RESET;
            enable_q <= '0;
            tlr_q    <= 8'h00;
        end else begin
            if (w_ctrl) begin
                ctrl_q <= wctrl;
            end
            if (w_enable) begin
                enable_q <= hwdata[NB-1:0];
            end
            if (w_tlr) begin
                tlr_q <= hwdata[7:0];
            end
        end
    end

    // direction pin: three stages, change accepted once the last two agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s_q   <= '0;
            dir_pin_q <= 1'b0;
        end else begin
            pin_s_q <= {pin_s_q[angle_pkg::SYNC_STAGES-2:0], trigger_direction_input};
            if (pin_s_q[2] == pin_s_q[1]) begin
                dir_pin_q <= pin_s_q[2];
            end
        end
    end

    logic          t_ev, s_ev, dir_now, dchg_t, dchg_s, dchg;
    logic [TW-1:0] dur_t, dur_s;
    assign t_ev    = events.trigger;
    assign s_ev    = events.state;
    assign dir_now = (ctrl_q.synchronous_motor_control | ctrl_q.dir_sel) ? dir_pin_q : events.dir_internal; // RL4
    assign dchg_t  = t_ev & (dir_now != dir_t_q);
    assign dchg_s  = s_ev & (dir_now != dir_s_q);
    assign dchg    = dchg_t | dchg_s;
    assign dur_t   = base_time_counter - ts_q;
    assign dur_s   = base_time_counter - ts_s_q;

    // out-of-range watch, armed by each trigger, fires once per increment
    logic [LW-1:0] lim_t;
    logic          tor_det;
    assign lim_t   = LW'(ts_q) + LW'(dt_q) * LW'(tlr_q);
    assign tor_det = arm_q & ~t_ev & (lim_t > LW'(base_time_counter)); // RL1

    logic pwi_det;
    assign pwi_det = t_ev & ~dchg & (pvt_q != '0) & (dur_t < pvt_q); // RL5 RL6

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ts_q    <= '0;
            ts_s_q  <= '0;
            dt_q    <= '0;
            arm_q   <= 1'b0;
            dir_t_q <= 1'b0;
            dir_s_q <= 1'b0;
        end else begin
            if (t_ev) begin
                ts_q    <= base_time_counter;
                dt_q    <= dur_t;
                dir_t_q <= dir_now;
            end
            if (s_ev) begin
                ts_s_q  <= base_time_counter;
                dir_s_q <= dir_now;
            end
            arm_q <= t_ev | (arm_q & ~tor_det);
        end
    end

    // notifications: hardware set wins over a software clear
    logic [NB-1:0] set_n;
    always_comb begin
        set_n        = '0;
        set_n[angle_pkg::N_TOR] = tor_det | seq_force_tor | (w_force & hwdata[angle_pkg::N_TOR]); // RL2 RL3
        set_n[angle_pkg::N_DCG] = dchg; // RL8
        set_n[angle_pkg::N_PWI] = pwi_det; // RL6
        if (w_force) begin
            set_n = set_n | hwdata[NB-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            notify_q   <= '0;
            tor_flag_q <= 1'b0;
        end else begin
            notify_q   <= (notify_q & ~(w_notify ? hwdata[NB-1:0] : '0)) | set_n; // RL16
            tor_flag_q <= (tor_flag_q & ~(w_status & hwdata[angle_pkg::S_TOR])) | tor_det; // RL2
        end
    end

    assign irq = notify_q & enable_q; // RL16

    // clear on direction change takes priority over any write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pvt_q <= '0;
        end else if (dchg) begin
            pvt_q <= '0; // RL5
        end else if (w_pvt) begin
            pvt_q <= hwdata[TW-1:0]; // RL7
        end else if (seq_pvt_we) begin
            pvt_q <= seq_pvt_wdata; // RL7
        end
    end

    // one correction per request, whether fast enable is on or switches on
    logic pc_set, pc_apply;
    assign pc_set   = w_ctrl & wctrl.pc_req;
    assign pc_apply = pc_pend_q & (ctrl_q.fast_corr | t_ev);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_pend_q <= 1'b0;
            mpv_q     <= 16'h0000;
        end else begin
            pc_pend_q <= pc_set | (pc_pend_q & ~pc_apply); // RL9
            if (w_mpv) begin
                mpv_q <= hwdata[15:0];
            end else if (pc_apply) begin
                mpv_q <= ctrl_q.pc_down ? mpv_q - 16'h0001 : mpv_q + 16'h0001; // RL9
            end
        end
    end

    logic [TW-1:0] step;
    assign step = dir_now ? '1 : TW'(1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pstc_q <= '0;
            pssc_q <= '0;
        end else begin
            if (w_pstc) begin
                pstc_q <= hwdata[TW-1:0];
            end else if (t_ev && !(dchg_t && !ctrl_q.sync_t)) begin
                pstc_q <= pstc_q + step; // RL11
            end
            if (w_pssc) begin
                pssc_q <= hwdata[TW-1:0];
            end else if (s_ev && !(dchg_s && !ctrl_q.sync_s)) begin
                pssc_q <= pssc_q + step; // RL12
            end
        end
    end

    logic [TW-1:0] rec_t, rec_s;
    logic          ovf_t, ovf_s;

    recip_unit #(.TW(TW)) u_recip_t (
        .duration (dur_t),
        .result   (rec_t),
        .overflow (ovf_t)
    );

    recip_unit #(.TW(TW)) u_recip_s (
        .duration (dur_s),
        .result   (rec_s),
        .overflow (ovf_s)
    );

    // results land in the trigger path normally, in the state path in emergency
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rcdt_t_q <= '0;
            rcdt_s_q <= '0;
            nom_t_q  <= '0;
            nom_s_q  <= '0;
            ovf_t_q  <= 1'b0;
            ovf_s_q  <= 1'b0;
        end else begin
            if (t_ev && !ctrl_q.emergency) begin
                rcdt_t_q <= rec_t; // RL13 RL14
                ovf_t_q  <= ovf_t;
                nom_t_q  <= ctrl_q.res_mode ? rec_t >> angle_pkg::RES_SHIFT : rec_t; // RL15
            end
            if (s_ev && ctrl_q.emergency) begin
                rcdt_s_q <= rec_s; // RL13 RL14
                ovf_s_q  <= ovf_s;
                nom_s_q  <= ctrl_q.res_mode ? rec_s >> angle_pkg::RES_SHIFT : rec_s; // RL15
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pulse_generator_addend <= '0;
        end else begin
            pulse_generator_addend <= ctrl_q.emergency ? nom_s_q : nom_t_q; // RL15
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence pin_held;
        $stable(trigger_direction_input) [*5];
    endsequence

    sequence normal_trigger;
        t_ev && !ctrl_q.emergency && !ctrl_q.res_mode;
    endsequence

    a_tor_detect: assert property ( // RL1
        (arm_q && !t_ev && lim_t > LW'(base_time_counter)) |=> tor_flag_q)
        else $error("out-of-range condition did not set the flag");
    a_tor_notify: assert property (tor_det |=> notify_q[angle_pkg::N_TOR] && tor_flag_q) // RL2
        else $error("out-of-range did not notify");
    a_force_tor: assert property ( // RL3
        (w_force && hwdata[angle_pkg::N_TOR]) || seq_force_tor |=> notify_q[angle_pkg::N_TOR])
        else $error("forced out-of-range not raised");
    a_dir_from_pin: assert property ( // RL4
        (pin_held ##0 (ctrl_q.synchronous_motor_control || ctrl_q.dir_sel)) |-> dir_now == trigger_direction_input)
        else $error("direction not taken from pin");
    a_pvt_cleared: assert property (dchg |-> !pwi_det ##1 pvt_q == '0) // RL5
        else $error("plausibility value not cleared on direction change");
    a_pwi_raise: assert property ( // RL6
        (t_ev && !dchg && pvt_q != '0 && dur_t < pvt_q) |=> notify_q[angle_pkg::N_PWI])
        else $error("plausibility violation not notified");
    a_seq_pvt_write: assert property ( // RL7
        (seq_pvt_we && !dchg && !w_pvt) |=> pvt_q == $past(seq_pvt_wdata))
        else $error("sequencer write to plausibility value lost");
    a_dir_change: assert property (dchg |=> notify_q[angle_pkg::N_DCG]) // RL8
        else $error("direction change not notified");
    a_pc_single: assert property ( // RL9
        (pc_apply && !w_mpv && !pc_set) |=> !pc_pend_q ##1 (w_mpv || pc_pend_q || $stable(mpv_q)))
        else $error("pulse correction applied more than once");
    a_pstc_hold: assert property ((dchg_t && !ctrl_q.sync_t && !w_pstc) |=> $stable(pstc_q)) // RL11
        else $error("trigger position counter moved while unsynchronized");
    a_pssc_hold: assert property ((dchg_s && !ctrl_q.sync_s && !w_pssc) |=> $stable(pssc_q)) // RL12
        else $error("state position counter moved while unsynchronized");
    a_recip_sat_t: assert property ((t_ev && !ctrl_q.emergency && ovf_t) |=> &rcdt_t_q) // RL13
        else $error("trigger reciprocal not saturated");
    a_recip_sat_s: assert property ((s_ev && ctrl_q.emergency && ovf_s) |=> &rcdt_s_q) // RL14
        else $error("state reciprocal not saturated");
    a_addend_path: assert property ( // RL15
        (normal_trigger ##1 !ctrl_q.emergency) |=> pulse_generator_addend == $past(rec_t, 2))
        else $error("addend does not follow trigger reciprocal");
    a_notify_sticky: assert property ( // RL16
        !w_notify |=> (notify_q & $past(notify_q)) == $past(notify_q))
        else $error("notification dropped without a clear");
endmodule : angle_clock_tracking_unit

// ===== verification/timer_input_model.sv
`timescale 1ns/1ns
// far-side timer input logic: event pulses, time base, direction pin, sequencer
module timer_input_model #(
    parameter int TW = angle_pkg::TW
) (
    input  wire logic            hclk,
    output angle_pkg::event_type events,
    output logic [TW-1:0]        base_time_counter,
    output logic                 trigger_direction_input,
    output logic                 seq_pvt_we,
    output logic [TW-1:0]        seq_pvt_wdata,
    output logic                 seq_force_tor
);
    logic [TW-1:0] stamp;
    logic [TW-1:0] skip;

    initial begin
        events = '0;
        base_time_counter = '0;
        trigger_direction_input = 1'b0;
        seq_pvt_we = 1'b0;
        seq_pvt_wdata = '0;
        seq_force_tor = 1'b0;
        skip = '0;
        stamp = '0;
    end

    // skip lets a long increment pass without waiting a million cycles
    always @(posedge hclk) begin
        base_time_counter <= base_time_counter + 24'h1 + skip;
        skip = '0;
    end

    task automatic pulse(input logic trg, input logic dir);
        @(posedge hclk);
        events <= '{state: ~trg, trigger: trg, dir_internal: dir};
        #1 stamp = base_time_counter;
        @(posedge hclk);
        events.trigger <= 1'b0;
        events.state   <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask : pulse

    task automatic jump(input logic [TW-1:0] d);
        @(negedge hclk);
        skip = d;
        @(posedge hclk);
    endtask : jump

    // pin is asynchronous to the block; give the synchronizer time to settle
    task automatic pin(input logic v);
        @(posedge hclk);
        trigger_direction_input <= v;
        repeat (8) @(posedge hclk);
    endtask : pin

    task automatic seq_pvt(input logic [TW-1:0] v);
        @(posedge hclk);
        seq_pvt_we    <= 1'b1;
        seq_pvt_wdata <= v;
        @(posedge hclk);
        seq_pvt_we    <= 1'b0;
        seq_pvt_wdata <= ~v;
        @(posedge hclk);
    endtask : seq_pvt

    task automatic force_tor;
        @(posedge hclk);
        seq_force_tor <= 1'b1;
        @(posedge hclk);
        seq_force_tor <= 1'b0;
        @(posedge hclk);
    endtask : force_tor
endmodule : timer_input_model

// ===== verification/angle_clock_tracking_unit_test.sv
`timescale 1ns/1ns
module angle_clock_tracking_unit_test;
    localparam int TW = angle_pkg::TW;
    logic                 hclk = 1'b0;
    logic                 hresetn = 1'b0;
    logic                 hsel = 1'b0;
    logic [31:0]          haddr = '0;
    logic [1:0]           htrans = '0;
    logic                 hwrite = 1'b0;
    logic [2:0]           hsize = 3'h2;
    logic [31:0]          hwdata = '0;
    logic                 hreadyout;
    logic                 hresp;
    logic [31:0]          hrdata;
    angle_pkg::event_type events;
    logic [TW-1:0]        base_time_counter;
    logic                 trigger_direction_input;
    logic                 seq_pvt_we;
    logic [TW-1:0]        seq_pvt_wdata;
    logic                 seq_force_tor;
    logic [2:0]           irq;
    logic [TW-1:0]        pulse_generator_addend;
    logic [31:0]          rdat;
    logic [TW-1:0]        s1;
    logic [TW-1:0]        d;
    logic [63:0]          e;
    int                   n_fail = 0;
    int                   checked = 0;
    int                   cycles = 0;

    always #4 hclk = ~hclk;

    angle_clock_tracking_unit dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .events,
        .base_time_counter, .trigger_direction_input, .seq_pvt_we, .seq_pvt_wdata,
        .seq_force_tor, .irq, .pulse_generator_addend);

    timer_input_model tim (.hclk, .events, .base_time_counter, .trigger_direction_input,
        .seq_pvt_we, .seq_pvt_wdata, .seq_force_tor);

    task automatic complete_run;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    // hang guard: the whole sequence needs a few hundred cycles
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= angle_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? wd : 32'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdat = hrdata;
        #1;
    endtask : bus

    task automatic rc(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] ex);
        bus(a, 1'b0, 32'h0);
        chk(rdat & mk, ex);
    endtask : rc

    task automatic clr;
        bus(angle_pkg::A_NOTIFY, 1'b1, 32'h7);
        bus(angle_pkg::A_STATUS, 1'b1, 32'h1);
    endtask : clr

    task automatic t_range;
        bus(angle_pkg::A_ENABLE, 1'b1, 32'h7);
        for (int i = 0; i < 4; i++) begin
            bus(angle_pkg::A_CTRL, 1'b1, i);
            bus(angle_pkg::A_TLR, 1'b1, 32'h0);
            clr();
            tim.pulse(1'b1, 1'b0);
            rc(angle_pkg::A_NOTIFY, 32'h1, 32'h0);
            bus(angle_pkg::A_TLR, 1'b1, 32'h2);
            tim.pulse(1'b1, 1'b0);
            rc(angle_pkg::A_STATUS, 32'h1, 32'h1);
            rc(angle_pkg::A_NOTIFY, 32'h1, 32'h1);
            chk({31'h0, irq[0]}, 32'h1);
        end
        bus(angle_pkg::A_NOTIFY, 1'b1, 32'h1);
        chk({31'h0, irq[0]}, 32'h0);
    endtask : t_range

    task automatic t_force;
        clr();
        bus(angle_pkg::A_FORCE, 1'b1, 32'h1);
        rc(angle_pkg::A_NOTIFY, 32'h7, 32'h1);
        rc(angle_pkg::A_FORCE, 32'hFFFFFFFF, 32'h0);
        clr();
        tim.force_tor();
        rc(angle_pkg::A_NOTIFY, 32'h7, 32'h1);
        bus(angle_pkg::A_ENABLE, 1'b1, 32'h0);
        chk({31'h0, irq[0]}, 32'h0);
        rc(angle_pkg::A_NOTIFY, 32'h1, 32'h1);
        bus(angle_pkg::A_ENABLE, 1'b1, 32'h7);
    endtask : t_force

    task automatic t_dir;
        bus(angle_pkg::A_CTRL, 1'b1, 32'h2);
        bus(angle_pkg::A_TLR, 1'b1, 32'h0);
        bus(angle_pkg::A_PSTC, 1'b1, 32'h5);
        bus(angle_pkg::A_PVT, 1'b1, 32'h64);
        clr();
        tim.pin(1'b1);
        tim.pulse(1'b1, 1'b0);
        rc(angle_pkg::A_NOTIFY, 32'h2, 32'h2);
        rc(angle_pkg::A_PVT, 32'hFFFFFF, 32'h0);
        rc(angle_pkg::A_PSTC, 32'hFFFFFF, 32'h5);
        clr();
        tim.pulse(1'b1, 1'b1);
        rc(angle_pkg::A_NOTIFY, 32'h2, 32'h0);
        rc(angle_pkg::A_PSTC, 32'hFFFFFF, 32'h4);
        bus(angle_pkg::A_CTRL, 1'b1, 32'h0);
        tim.pin(1'b0);
        clr();
        tim.pulse(1'b1, 1'b1);
        rc(angle_pkg::A_NOTIFY, 32'h2, 32'h0);
        bus(angle_pkg::A_CTRL, 1'b1, 32'h4);
        tim.pulse(1'b1, 1'b1);
        rc(angle_pkg::A_NOTIFY, 32'h2, 32'h2);
    endtask : t_dir

    task automatic t_pvt;
        bus(angle_pkg::A_CTRL, 1'b1, 32'h0);
        tim.pulse(1'b1, 1'b1);
        bus(angle_pkg::A_PVT, 1'b1, 32'h123);
        rc(angle_pkg::A_PVT, 32'hFFFFFF, 32'h123);
        tim.seq_pvt(24'hFFFFFF);
        rc(angle_pkg::A_PVT, 32'hFFFFFF, 32'hFFFFFF);
        clr();
        tim.pulse(1'b1, 1'b1);
        rc(angle_pkg::A_NOTIFY, 32'h4, 32'h4);
        bus(angle_pkg::A_PVT, 1'b1, 32'h0);
        clr();
        tim.pulse(1'b1, 1'b1);
        rc(angle_pkg::A_NOTIFY, 32'h4, 32'h0);
    endtask : t_pvt

    task automatic t_corr;
        bus(angle_pkg::A_MPV, 1'b0, 32'h0);
        e = {32'h0, rdat};
        bus(angle_pkg::A_CTRL, 1'b1, 32'h20);
        tim.pulse(1'b1, 1'b1);
        tim.pulse(1'b1, 1'b1);
        rc(angle_pkg::A_MPV, 32'hFFFF, (e[31:0] + 32'h1) & 32'hFFFF);
        bus(angle_pkg::A_CTRL, 1'b1, 32'h20);
        bus(angle_pkg::A_CTRL, 1'b1, 32'h8);
        tim.pulse(1'b1, 1'b1);
        tim.pulse(1'b1, 1'b1);
        rc(angle_pkg::A_MPV, 32'hFFFF, (e[31:0] + 32'h2) & 32'hFFFF);
        bus(angle_pkg::A_CTRL, 1'b1, 32'h60);
        tim.pulse(1'b1, 1'b1);
        rc(angle_pkg::A_MPV, 32'hFFFF, (e[31:0] + 32'h1) & 32'hFFFF);
        bus(angle_pkg::A_CTRL, 1'b1, 32'h0);
    endtask : t_corr

    task automatic t_state;
        bus(angle_pkg::A_PSSC, 1'b1, 32'h7);
        clr();
        tim.pulse(1'b0, 1'b1);
        rc(angle_pkg::A_PSSC, 32'hFFFFFF, 32'h7);
        rc(angle_pkg::A_NOTIFY, 32'h2, 32'h2);
        tim.pulse(1'b0, 1'b1);
        rc(angle_pkg::A_PSSC, 32'hFFFFFF, 32'h6);
    endtask : t_state

    task automatic t_recip;
        bus(angle_pkg::A_CTRL, 1'b1, 32'h1);
        tim.pulse(1'b1, 1'b1);
        tim.pulse(1'b1, 1'b1);
        rc(angle_pkg::A_RCDT_T, 32'hFFFFFF, 32'hFFFFFF);
        rc(angle_pkg::A_STATUS, 32'h20, 32'h20);
        rc(angle_pkg::A_NOM_T, 32'hFFFFFF, 32'h1FFFFF);
        bus(angle_pkg::A_CTRL, 1'b1, 32'h0);
        tim.pulse(1'b1, 1'b1);
        s1 = tim.stamp;
        tim.jump(24'h100000);
        tim.pulse(1'b1, 1'b1);
        d = tim.stamp - s1;
        e = 64'h10000000000 / d;
        rc(angle_pkg::A_RCDT_T, 32'hFFFFFF, e[31:0]);
        rc(angle_pkg::A_NOM_T, 32'hFFFFFF, e[31:0]);
        chk({8'h0, pulse_generator_addend}, e[31:0]);
        bus(angle_pkg::A_CTRL, 1'b1, 32'h10);
        tim.pulse(1'b1, 1'b1);
        tim.pulse(1'b0, 1'b1);
        tim.pulse(1'b0, 1'b1);
        rc(angle_pkg::A_RCDT_S, 32'hFFFFFF, 32'hFFFFFF);
        rc(angle_pkg::A_RCDT_T, 32'hFFFFFF, e[31:0]);
    endtask : t_recip

    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_range();
        t_force();
        t_dir();
        t_pvt();
        t_corr();
        t_state();
        t_recip();
        complete_run();
    end
endmodule : angle_clock_tracking_unit_test
